/* File: rtl/eft_timer.sv */
// Fine mode eight bit timer with an AXI4-Lite register slave.
// Assumes prescaler taps and the bus run on aclk; tap 0 is always high.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eft_defines.svh"

module eft_timer (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [14:0] psc_tap,
	input  wire logic [31:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [31:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             uart_clk,
	output logic             irq_req
);
	import eft_pkg::*;

	// ----------------------------------------------------------------
	// Bus slave.
	// ----------------------------------------------------------------
	logic             awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic             aw_got_r, w_got_r;
	logic [31:0]      awaddr_r, wdata_r, rdata_r;
	logic [3:0]       wstrb_r;
	logic [1:0]       bresp_r, rresp_r;
	logic             aw_hs, w_hs, ar_hs, wr_fire;
	logic             aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;

	logic [3:0]       df_r;
	logic [7:0]       reload_r;
	logic [7:0]       cnt_r;
	logic             mode_r;
	logic [3:0]       fine_r;
	logic [3:0]       idx_r;
	eft_state_t       state_r;
	logic             uf_r, irq_r;

	assign aw_hs   = awvalid && awready_r;
	assign w_hs    = wvalid && wready_r;
	assign ar_hs   = arvalid && arready_r;
	assign wr_fire = aw_got_r && w_got_r && !bvalid_r;

	assign aw_got_nxt = wr_fire ? 1'b0 : (aw_got_r || aw_hs);
	assign w_got_nxt  = wr_fire ? 1'b0 : (w_got_r || w_hs);
	assign bvalid_nxt = wr_fire ? 1'b1 : (bvalid_r && !bready);
	assign rvalid_nxt = ar_hs ? 1'b1 : (rvalid_r && !rready);

	function automatic logic idx_ok(input logic [31:0] a,
	                                input logic [15:0] idx);
		idx_ok = (a[31:18] == 14'h0) && (a[17:2] == idx);
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = idx_ok(a, `EFT_IDX_CLK) || idx_ok(a, `EFT_IDX_RELOAD) ||
		         idx_ok(a, `EFT_IDX_COUNT) || idx_ok(a, `EFT_IDX_CTL);
	endfunction

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
		end else begin
			aw_got_r  <= aw_got_nxt;
			w_got_r   <= w_got_nxt;
			bvalid_r  <= bvalid_nxt;
			awready_r <= !aw_got_nxt && !bvalid_nxt;
			wready_r  <= !w_got_nxt && !bvalid_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_r <= 32'h0;
			wdata_r  <= 32'h0;
			wstrb_r  <= 4'h0;
			bresp_r  <= `EFT_RESP_OKAY;
		end else begin
			if (aw_hs)
				awaddr_r <= awaddr;
			if (w_hs) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_fire)
				bresp_r <= mapped(awaddr_r) ? `EFT_RESP_OKAY
				                            : `EFT_RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b0;
			rdata_r   <= 32'h0;
			rresp_r   <= `EFT_RESP_OKAY;
		end else begin
			rvalid_r  <= rvalid_nxt;
			arready_r <= !rvalid_nxt;
			if (ar_hs) begin
				rresp_r <= `EFT_RESP_OKAY;
				if (idx_ok(araddr, `EFT_IDX_CLK)) begin
					rdata_r <= {28'h0, df_r};
				end else if (idx_ok(araddr, `EFT_IDX_RELOAD)) begin
					rdata_r <= {24'h0, reload_r};
				end else if (idx_ok(araddr, `EFT_IDX_COUNT)) begin
					rdata_r <= {24'h0, cnt_r};
				end else if (idx_ok(araddr, `EFT_IDX_CTL)) begin
					rdata_r <= {20'h0, fine_r, 3'h0, mode_r, 3'h0,
					            state_r != ST_STOP};
				end else begin
					rdata_r <= 32'h0;
					rresp_r <= `EFT_RESP_SLVERR;
				end
			end
		end
	end

	assign awready = awready_r;
	assign wready  = wready_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	logic clk_wr, rel_wr, ctl_wr_lo, ctl_wr_hi, preset_wr;

	assign clk_wr    = wr_fire && wstrb_r[0] && idx_ok(awaddr_r, `EFT_IDX_CLK);
	assign rel_wr    = wr_fire && wstrb_r[0] &&
	                   idx_ok(awaddr_r, `EFT_IDX_RELOAD);
	assign ctl_wr_lo = wr_fire && wstrb_r[0] && idx_ok(awaddr_r, `EFT_IDX_CTL);
	assign ctl_wr_hi = wr_fire && wstrb_r[1] && idx_ok(awaddr_r, `EFT_IDX_CTL);
	assign preset_wr = ctl_wr_lo && wdata_r[`EFT_BIT_PRESET];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			df_r     <= `EFT_RST_DF;
			reload_r <= `EFT_RST_RELOAD;
			mode_r   <= 1'b0;
			fine_r   <= `EFT_RST_FINE;
		end else begin
			if (clk_wr)
				df_r <= wdata_r[3:0];
			if (rel_wr)
				reload_r <= wdata_r[7:0];
			if (ctl_wr_lo)
				mode_r <= wdata_r[`EFT_BIT_MODE];
			if (ctl_wr_hi)
				fine_r <= wdata_r[`EFT_FINE_LSB +: 4];
		end
	end

	// ----------------------------------------------------------------
	// Count clock and counter.
	// ----------------------------------------------------------------
	logic tick, fine_hit, underflow;

	// Taps are enables on aclk, so the selection needs no synchroniser.
	assign tick = (df_r != `EFT_DF_RESERVED) && psc_tap[df_r];
	assign fine_hit = eft_fine_rank(idx_r) < fine_r;
	assign underflow = !ctl_wr_lo && tick &&
	                   ((state_r == ST_RUN && cnt_r == 8'h0 && !fine_hit) ||
	                    state_r == ST_DELAY);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_STOP;
		end else if (ctl_wr_lo) begin
			// A control write wins over a count clock in the same cycle.
			if (!wdata_r[`EFT_BIT_RUN])
				state_r <= ST_STOP;
			else if (state_r == ST_STOP || preset_wr)
				state_r <= ST_RUN;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (tick && cnt_r == 8'h0)
						state_r <= fine_hit ? ST_DELAY :
						           (mode_r ? ST_STOP : ST_RUN);
				end
				ST_DELAY: begin
					if (tick)
						state_r <= mode_r ? ST_STOP : ST_RUN;
				end
				default: state_r <= state_r;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= `EFT_RST_COUNT;
		end else if (preset_wr || underflow) begin
			cnt_r <= reload_r;
		end else if (!ctl_wr_lo && state_r == ST_RUN && tick &&
		             cnt_r != 8'h0) begin
			cnt_r <= cnt_r - 8'h1;
		end
	end

	// Slot index walks the sixteen-underflow fine pattern.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			idx_r <= 4'h0;
		else if (underflow)
			idx_r <= idx_r + 4'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uf_r  <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			uf_r  <= underflow;
			irq_r <= underflow;
		end
	end

	assign uart_clk = uf_r;
	assign irq_req  = irq_r;

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_uf_reload: assert property (
		$rose(uf_r) |-> cnt_r == reload_r)
		else $error("Counter not reloaded on underflow.");
	chk_oneshot_stop: assert property (
		underflow && mode_r |=> state_r == ST_STOP)
		else $error("One-shot did not stop.");
	chk_repeat_run: assert property (
		underflow && !mode_r |=> state_r == ST_RUN && uf_r)
		else $error("Repeat mode did not continue.");
	chk_irq_pair: assert property (
		irq_r == uf_r)
		else $error("Request and UART clock differ.");
	chk_count_dec: assert property (
		state_r == ST_RUN && tick && cnt_r != 8'h0 && !ctl_wr_lo
		|=> cnt_r == $past(cnt_r) - 8'h1)
		else $error("Counter did not decrement.");
	chk_stop_hold: assert property (
		state_r == ST_STOP && !preset_wr |=> $stable(cnt_r))
		else $error("Stopped counter changed.");
	chk_preset_load: assert property (
		preset_wr && wdata_r[`EFT_BIT_RUN]
		|=> cnt_r == $past(reload_r) && state_r == ST_RUN)
		else $error("Preset did not load or stopped.");
	chk_no_fine: assert property (
		fine_r == 4'h0 |-> state_r != ST_DELAY)
		else $error("Delay inserted with fine zero.");
	chk_first_slot: assert property (
		state_r == ST_DELAY |-> idx_r != 4'h0)
		else $error("First underflow delayed.");
	chk_reserved_df: assert property (
		df_r == `EFT_DF_RESERVED |-> !tick)
		else $error("Reserved clock select ticks.");

	cov_oneshot: cover property (underflow && mode_r);
	cov_delay: cover property (state_r == ST_RUN ##1 state_r == ST_DELAY);
	cov_preset_run: cover property (preset_wr && state_r == ST_RUN);

endmodule // eft_timer
`default_nettype wire

/* File: include/eft_defines.svh */
// Constants for the fine mode eight bit timer: offsets, fields, resets.
// Assumes inclusion by the timer module and the testbench only.
`ifndef EFT_DEFINES_SVH
`define EFT_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices; byte address is four times the index.
// ----------------------------------------------------------------
`define EFT_IDX_CLK     16'h4200
`define EFT_IDX_RELOAD  16'h4202
`define EFT_IDX_COUNT   16'h4204
`define EFT_IDX_CTL     16'h4206

// ----------------------------------------------------------------
// Control fields.
// ----------------------------------------------------------------
`define EFT_BIT_RUN     0
`define EFT_BIT_PRESET  1
`define EFT_BIT_MODE    4
`define EFT_FINE_LSB    8
`define EFT_DF_RESERVED 4'hf

// ----------------------------------------------------------------
// Reset values and responses.
// ----------------------------------------------------------------
`define EFT_RST_DF      4'h0
`define EFT_RST_RELOAD  8'h00
`define EFT_RST_COUNT   8'h00
`define EFT_RST_FINE    4'h0
`define EFT_RESP_OKAY   2'b00
`define EFT_RESP_SLVERR 2'b10

`endif

/* File: include/eft_pkg.sv */
// Types shared by the fine mode eight bit timer.
// Assumes nothing beyond the constants header.
package eft_pkg;

	typedef enum logic [2:0] {
		ST_STOP  = 3'b001,
		ST_RUN   = 3'b010,
		ST_DELAY = 3'b100
	} eft_state_t;

	// Rank of an underflow slot in the order that delays are added.
	// Slot 0 is the first underflow and ranks last, so it is never delayed.
	function automatic logic [3:0] eft_fine_rank(input logic [3:0] idx);
		case (idx)
			4'hf: eft_fine_rank = 4'h0;
			4'h7: eft_fine_rank = 4'h1;
			4'hb: eft_fine_rank = 4'h2;
			4'h3: eft_fine_rank = 4'h3;
			4'hd: eft_fine_rank = 4'h4;
			4'h5: eft_fine_rank = 4'h5;
			4'h9: eft_fine_rank = 4'h6;
			4'h1: eft_fine_rank = 4'h7;
			4'he: eft_fine_rank = 4'h8;
			4'h6: eft_fine_rank = 4'h9;
			4'ha: eft_fine_rank = 4'ha;
			4'h2: eft_fine_rank = 4'hb;
			4'hc: eft_fine_rank = 4'hc;
			4'h4: eft_fine_rank = 4'hd;
			4'h8: eft_fine_rank = 4'he;
			default: eft_fine_rank = 4'hf;
		endcase
	endfunction

endpackage

/* File: test/eft_partner.sv */
// Partner model: the UART transfer clock input and the interrupt controller.
// Assumes both pulses arrive registered on aclk.
`timescale 1ns/1ps
`default_nettype none

module eft_partner (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        uart_clk,
	input  wire logic        irq_req,
	output logic      [31:0] pulse_count,
	output logic      [31:0] stamp,
	output logic      [31:0] mismatch_count
);
	logic [31:0] cyc_r;

	// ----------------------------------------------------------------
	// Pulse capture.
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cyc_r          <= 32'h0;
			pulse_count    <= 32'h0;
			stamp          <= 32'h0;
			mismatch_count <= 32'h0;
		end else begin
			cyc_r <= cyc_r + 32'h1;
			if (uart_clk === 1'b1) begin
				pulse_count <= pulse_count + 32'h1;
				stamp       <= cyc_r;
			end
			if (irq_req !== uart_clk)
				mismatch_count <= mismatch_count + 32'h1;
		end
	end
endmodule // eft_partner
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the fine mode eight bit timer.
// Assumes the partner model; the bench acts as AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "eft_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	n_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end

module testbench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, uart_clk, irq_req;
	logic [31:0] awaddr, wdata, araddr, rdata, d, v1, v2, v3, c0;
	logic [31:0] pulse_count, stamp, mismatch_count;
	logic [15:0] pc;
	logic [14:0] psc_tap;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	int          n_errors, total_checks;

	eft_timer eft_timer_i (.aclk(aclk), .aresetn(aresetn), .psc_tap(psc_tap),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .uart_clk(uart_clk), .irq_req(irq_req));
	eft_partner eft_partner_i (.aclk(aclk), .aresetn(aresetn),
		.uart_clk(uart_clk), .irq_req(irq_req), .pulse_count(pulse_count),
		.stamp(stamp), .mismatch_count(mismatch_count));

	// ----------------------------------------------------------------
	// Clock and prescaler taps; tap n ticks every 2^n cycles.
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	function automatic logic [14:0] taps(input logic [15:0] c);
		for (int j = 0; j < 15; j++)
			taps[j] = (c & ((16'h1 << j) - 16'h1)) == 16'h0;
	endfunction
	always @(posedge aclk) begin
		pc      <= pc + 16'h1;
		psc_tap <= taps(pc + 16'h1);
	end

	// ----------------------------------------------------------------
	// Bus tasks.
	// ----------------------------------------------------------------
	task automatic wr(input logic [15:0] i, input logic [31:0] dv);
		int k;
		begin
			@(posedge aclk);
			awaddr  <= {14'h0, i, 2'b00};
			wdata   <= dv;
			awvalid <= 1'b1;
			wvalid  <= 1'b1;
			bready  <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				if (awvalid && awready) awvalid <= 1'b0;
				if (wvalid && wready) wvalid <= 1'b0;
				k++;
			end while (!bvalid && k < 100);
			bready <= 1'b0;
			if (!bvalid) begin
				n_errors++;
				test_done;
			end
		end
	endtask
	task automatic rd(input logic [15:0] i, output logic [31:0] dv,
		output logic [1:0] rv);
		int k;
		begin
			@(posedge aclk);
			araddr  <= {14'h0, i, 2'b00};
			arvalid <= 1'b1;
			rready  <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				if (arvalid && arready) arvalid <= 1'b0;
				k++;
			end while (!rvalid && k < 100);
			rready <= 1'b0;
			dv = rdata;
			rv = rresp;
			if (!rvalid) begin
				n_errors++;
				test_done;
			end
		end
	endtask
	task automatic waitp(input int n);
		logic [31:0] tg;
		tg = pulse_count + n;
		for (int k = 0; k < 3000 && pulse_count < tg; k++)
			@(posedge aclk);
		if (pulse_count < tg) begin
			n_errors++;
			test_done;
		end
	endtask
	// Sixteen intervals cover every fine slot whatever the phase.
	task automatic period(input logic [3:0] sel, input logic [7:0] rl,
		input logic [3:0] fn);
		logic [31:0] t0;
		begin
			wr(`EFT_IDX_CTL, 32'h0);
			wr(`EFT_IDX_CLK, {28'h0, sel});
			wr(`EFT_IDX_RELOAD, {24'h0, rl});
			wr(`EFT_IDX_CTL, {20'h0, fn, 8'h03});
			waitp(1);
			t0 = stamp;
			waitp(16);
			`CHK("period", (32'd16 * (rl + 32'd1) + fn) << sel, stamp - t0)
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests.
	// ----------------------------------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, wdata, araddr, pc, psc_tap} = '0;
		wstrb = 4'hf;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`EFT_IDX_CLK, d, r);
		`CHK("clk sel", {28'h0, `EFT_RST_DF}, d)
		rd(`EFT_IDX_CTL, d, r);
		`CHK("ctl", 32'h0, d)
		rd(`EFT_IDX_COUNT, d, r);
		`CHK("counter", {24'h0, `EFT_RST_COUNT}, d)
		rd(16'h4208, d, r);
		`CHK("unmapped", `EFT_RESP_SLVERR, r)
		$display("test reset done");
		for (int s = 0; s < 3; s++)
			period(s[3:0], 8'h03, 4'h0);
		period(4'h0, 8'h00, 4'h1);
		period(4'h0, 8'h01, 4'h8);
		period(4'h1, 8'h01, 4'hf);
		$display("test period done");
		wr(`EFT_IDX_CTL, 32'h0);
		wr(`EFT_IDX_RELOAD, 32'h5);
		c0 = pulse_count;
		wr(`EFT_IDX_CTL, 32'h13);
		waitp(1);
		repeat (40) @(posedge aclk);
		`CHK("one shot", c0 + 32'h1, pulse_count)
		rd(`EFT_IDX_CTL, d, r);
		`CHK("auto stop", 32'h10, d)
		rd(`EFT_IDX_COUNT, d, r);
		`CHK("reloaded", 32'h5, d)
		$display("test one shot done");
		wr(`EFT_IDX_CTL, 32'h0);
		wr(`EFT_IDX_RELOAD, 32'hc8);
		wr(`EFT_IDX_CTL, 32'h3);
		repeat (20) @(posedge aclk);
		wr(`EFT_IDX_CTL, 32'h0);
		rd(`EFT_IDX_COUNT, v1, r);
		repeat (30) @(posedge aclk);
		rd(`EFT_IDX_COUNT, v2, r);
		`CHK("hold", v1, v2)
		wr(`EFT_IDX_CTL, 32'h1);
		rd(`EFT_IDX_COUNT, v3, r);
		`CHK("resume", 1'b1, v3 < v1)
		wr(`EFT_IDX_CTL, 32'h3);
		rd(`EFT_IDX_COUNT, d, r);
		`CHK("preset run", 1'b1, d > v3 && d <= 32'hc8)
		rd(`EFT_IDX_CTL, d, r);
		`CHK("still run", 32'h1, d)
		$display("test stop done");
		wr(`EFT_IDX_CTL, 32'h0);
		wr(`EFT_IDX_CLK, {28'h0, `EFT_DF_RESERVED});
		wr(`EFT_IDX_RELOAD, 32'h9);
		wr(`EFT_IDX_CTL, 32'h3);
		repeat (50) @(posedge aclk);
		rd(`EFT_IDX_COUNT, d, r);
		`CHK("no tick", 32'h9, d)
		`CHK("irq copy", 32'h0, mismatch_count)
		$display("test reserved done");
		test_done;
	end

	initial begin
		#800000;
		n_errors++;
		test_done;
	end
endmodule // testbench
`default_nettype wire
